/* File: hw/key_request_target_decoder.sv */
// Decoder of report-target descriptor and key-derivation request blocks
`timescale 1ns/10ps
`include "param_decode_map.svh"

module key_request_target_decoder
	import param_decode_pkg::*;
(
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  srst,
	// Operation start
	input  wire logic                  start,
	input  param_decode_pkg::op_kind_t op,
	input  wire logic [63:0]           pointer_register,
	input  wire logic                  cap_ctl_flow,
	// Block memory read port, one cycle latency
	output logic                       mem_rd,
	output logic [63:0]                mem_addr,
	input  wire logic [63:0]           mem_data,
	// Enclave identity inputs
	input  wire logic [255:0]          own_enclave_measurement,
	input  wire logic [255:0]          own_signer_measurement,
	input  wire logic [127:0]          own_attributes,
	input  wire logic [31:0]           own_misc_select,
	input  wire logic [7:0]            own_control_flow_attrs,
	input  wire logic [15:0]           own_product_identifier,
	input  wire logic [511:0]          own_config_identifier,
	input  wire logic [127:0]          own_family_identifier,
	input  wire logic [127:0]          own_extended_product_id,
	// Results
	output logic                       done,
	output logic                       fault,
	output param_decode_pkg::key_kind_t key_kind,
	output logic [255:0]               tgt_measurement,
	output logic [127:0]               tgt_attributes,
	output logic [7:0]                 tgt_control_flow_attrs,
	output logic [15:0]                tgt_config_version,
	output logic [31:0]                tgt_misc_select,
	output logic [511:0]               tgt_config_identifier,
	output logic [15:0]                vendor_version,
	output logic [127:0]               processor_version,
	output logic [255:0]               wearout_nonce,
	output logic [15:0]                config_version,
	output logic [127:0]               drv_attributes,
	output logic [31:0]                drv_misc_select,
	output logic [7:0]                 drv_control_flow_attrs,
	output logic [255:0]               drv_enclave_measurement,
	output logic [255:0]               drv_signer_measurement,
	output logic [15:0]                drv_product_identifier,
	output logic [511:0]               drv_config_identifier,
	output logic [127:0]               drv_family_identifier,
	output logic [127:0]               drv_extended_product_id
);
	import param_decode_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		ST_IDLE,
		ST_READ,
		ST_FINISH
	} state_t;

	state_t                  state_q;
	op_kind_t                op_q;
	logic [63:0]             base_q;
	logic                    cap_q;
	logic [6:0]              idx_q;
	logic                    rvalid_q;
	logic [5:0]              ridx_q;
	logic                    rsv_err_q;
	logic [15:0]             sel_q;
	logic [15:0]             pol_q;
	logic [7:0]              cfam_q;
	logic [127:0]            amask_q;
	logic [31:0]             mmask_q;
	key_kind_t               kind_w;
	logic                    sel_rsv_w;
	logic                    word_rsv_w;

	// Byte address of word index within the block
	function automatic logic [63:0] word_addr(input logic [63:0] base, input logic [6:0] i);
		word_addr = base + {55'h0, i[5:0], 3'h0};
	endfunction

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_q <= ST_IDLE;
			idx_q   <= 7'h00;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
					if (start && op != OP_NONE)
					begin
						if (pointer_register[`BLK_ALIGN_BITS-1:0] != 9'h000)
							state_q <= ST_FINISH;
						else
							state_q <= ST_READ;
						idx_q <= 7'h00;
					end
				ST_READ:
					if (idx_q == 7'(`WORD_COUNT))
						state_q <= ST_FINISH;
					else
						idx_q <= idx_q + 7'h01;
				ST_FINISH:
					if (!rvalid_q)
						state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			op_q   <= OP_NONE;
			base_q <= 64'h0;
			cap_q  <= 1'b0;
		end
		else if (state_q == ST_IDLE && start)
		begin
			op_q   <= op;
			base_q <= pointer_register;
			cap_q  <= cap_ctl_flow;
		end
	end

	// Memory port: one word per cycle over the 512-byte block
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			mem_rd   <= 1'b0;
			mem_addr <= 64'h0;
			rvalid_q <= 1'b0;
			ridx_q   <= 6'h00;
		end
		else
		begin
			mem_rd   <= (state_q == ST_READ) && (idx_q < 7'(`WORD_COUNT));
			mem_addr <= word_addr(base_q, idx_q);
			rvalid_q <= mem_rd;
			ridx_q   <= mem_addr[8:3] - base_q[8:3];
		end
	end

	// ----------------------------------------
	// Reserved field checks per word
	// ----------------------------------------
	always_comb
	begin
		word_rsv_w = 1'b0;
		if (op_q == OP_REPORT_GENERATE)
		begin
			// bytes 48..63, byte 48 reserved without capability
			if (ridx_q == 6'd6 && (mem_data[15:8] != 8'h00 || (!cap_q && mem_data[7:0] != 8'h00)))
				word_rsv_w = 1'b1;
			if (ridx_q == 6'd7 && mem_data != 64'h0)
				word_rsv_w = 1'b1;
			if (ridx_q >= 6'd16 && mem_data != 64'h0)
				word_rsv_w = 1'b1;
		end
		else
		begin
			// byte 6 without capability, byte 7, policy high bits
			if (ridx_q == 6'd0 && (mem_data[63:56] != 8'h00 ||
			    (!cap_q && mem_data[55:48] != 8'h00) ||
			    (mem_data[31:16] & `POL_RSV_MASK) != 16'h0000))
				word_rsv_w = 1'b1;
			if (ridx_q == 6'd9 && mem_data[63:48] != 16'h0000)
				word_rsv_w = 1'b1;
			if (ridx_q >= 6'd10 && mem_data != 64'h0)
				word_rsv_w = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst || (state_q == ST_IDLE && start))
			rsv_err_q <= 1'b0;
		else if (rvalid_q && word_rsv_w)
			rsv_err_q <= 1'b1;
	end

	// ----------------------------------------
	// Field capture
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tgt_measurement        <= 256'h0;
			tgt_attributes         <= 128'h0;
			tgt_control_flow_attrs <= 8'h00;
			tgt_config_version     <= 16'h0000;
			tgt_misc_select        <= 32'h0;
			tgt_config_identifier  <= 512'h0;
		end
		else if (rvalid_q && op_q == OP_REPORT_GENERATE)
		begin
			if (ridx_q < 6'd4)
				tgt_measurement[ridx_q[1:0]*64 +: 64] <= mem_data;
			if (ridx_q == 6'd4 || ridx_q == 6'd5)
				tgt_attributes[ridx_q[0]*64 +: 64] <= mem_data;
			if (ridx_q == 6'd6)
			begin
				tgt_control_flow_attrs <= cap_q ? mem_data[7:0] : 8'h00;
				tgt_config_version     <= mem_data[31:16];
				tgt_misc_select        <= mem_data[63:32];
			end
			if (ridx_q >= 6'd8 && ridx_q < 6'd16)
				tgt_config_identifier[ridx_q[2:0]*64 +: 64] <= mem_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			sel_q             <= 16'h0000;
			pol_q             <= 16'h0000;
			vendor_version    <= 16'h0000;
			cfam_q            <= 8'h00;
			processor_version <= 128'h0;
			amask_q           <= 128'h0;
			wearout_nonce     <= 256'h0;
			mmask_q           <= 32'h0;
			config_version    <= 16'h0000;
		end
		else if (rvalid_q && op_q == OP_KEY_FETCH)
		begin
			if (ridx_q == 6'd0)
			begin
				sel_q          <= mem_data[15:0];
				pol_q          <= mem_data[31:16];
				vendor_version <= mem_data[47:32];
				cfam_q         <= cap_q ? mem_data[55:48] : 8'h00;
			end
			if (ridx_q == 6'd1 || ridx_q == 6'd2)
				processor_version[(ridx_q[1:0]-2'd1)*64 +: 64] <= mem_data;
			if (ridx_q == 6'd3 || ridx_q == 6'd4)
				amask_q[(ridx_q[2:0]-3'd3)*64 +: 64] <= mem_data;
			if (ridx_q >= 6'd5 && ridx_q < 6'd9)
				wearout_nonce[(ridx_q[3:0]-4'd5)*64 +: 64] <= mem_data;
			if (ridx_q == 6'd9)
			begin
				mmask_q        <= mem_data[31:0];
				config_version <= mem_data[47:32];
			end
		end
	end

	key_selector_decode u_sel
	(
		.sel_raw  (sel_q),
		.kind     (kind_w),
		.reserved (sel_rsv_w)
	);

	// ----------------------------------------
	// Result and derivation inputs
	// ----------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			done                    <= 1'b0;
			fault                   <= 1'b0;
			key_kind                <= KEY_RESERVED;
			drv_attributes          <= 128'h0;
			drv_misc_select         <= 32'h0;
			drv_control_flow_attrs  <= 8'h00;
			drv_enclave_measurement <= 256'h0;
			drv_signer_measurement  <= 256'h0;
			drv_product_identifier  <= 16'h0000;
			drv_config_identifier   <= 512'h0;
			drv_family_identifier   <= 128'h0;
			drv_extended_product_id <= 128'h0;
		end
		else
		begin
			done <= (state_q == ST_FINISH) && !rvalid_q;
			if (state_q == ST_FINISH && !rvalid_q)
			begin
				fault <= (base_q[`BLK_ALIGN_BITS-1:0] != 9'h000) || rsv_err_q ||
				         (op_q == OP_KEY_FETCH && sel_rsv_w);
				key_kind <= kind_w;
				drv_attributes  <= own_attributes & amask_q;
				drv_misc_select <= own_misc_select & mmask_q;
				drv_control_flow_attrs <= own_control_flow_attrs & cfam_q;
				drv_enclave_measurement <= pol_q[`POL_ENCL_BIT] ? own_enclave_measurement : 256'h0;
				drv_signer_measurement  <= pol_q[`POL_SIGN_BIT] ? own_signer_measurement : 256'h0;
				drv_product_identifier  <= pol_q[`POL_OMIT_PROD_BIT] ? 16'h0000 : own_product_identifier;
				drv_config_identifier   <= pol_q[`POL_CFGID_BIT] ? own_config_identifier : 512'h0;
				drv_family_identifier   <= pol_q[`POL_FAMILY_BIT] ? own_family_identifier : 128'h0;
				drv_extended_product_id <= pol_q[`POL_EXTPROD_BIT] ? own_extended_product_id : 128'h0;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_misalign_fault: assert property (@(posedge clk) disable iff (srst)
		(state_q == ST_IDLE && start && op != OP_NONE && pointer_register[8:0] != 9'h000)
		|-> ##[1:4] (done && fault)) else $error("misaligned block did not fault");
	a_done_pulse: assert property (@(posedge clk) disable iff (srst)
		done |=> !done) else $error("done longer than one cycle");
	a_no_read_misalign: assert property (@(posedge clk) disable iff (srst)
		mem_rd |-> mem_addr[2:0] == 3'h0) else $error("unaligned word read");
	a_omit_prod: assert property (@(posedge clk) disable iff (srst)
		(done && pol_q[2]) |-> drv_product_identifier == 16'h0000) else $error("product id kept");
	a_encl_meas: assert property (@(posedge clk) disable iff (srst)
		(done && !pol_q[0]) |-> drv_enclave_measurement == 256'h0) else $error("measurement kept");
	a_attr_mask: assert property (@(posedge clk) disable iff (srst)
		done |-> (drv_attributes & ~amask_q) == 128'h0) else $error("attribute mask leak");
	a_misc_mask: assert property (@(posedge clk) disable iff (srst)
		done |-> (drv_misc_select & ~mmask_q) == 32'h0) else $error("misc mask leak");
	a_sel_fault: assert property (@(posedge clk) disable iff (srst)
		(done && op_q == OP_KEY_FETCH && sel_q > 16'h0004) |-> fault) else $error("reserved key ok");
	a_sel_reserved: assert property (@(posedge clk) disable iff (srst)
		sel_rsv_w == (sel_q > `SEL_MAX)) else $error("reserved selector not flagged");
	a_cfa_gate: assert property (@(posedge clk) disable iff (srst)
		!cap_q && op_q == OP_REPORT_GENERATE && done |-> tgt_control_flow_attrs == 8'h00)
		else $error("control-flow byte used without capability");

	c_report_ok: cover property (@(posedge clk) done && !fault && op_q == OP_REPORT_GENERATE);
	c_key_ok: cover property (@(posedge clk) done && !fault && op_q == OP_KEY_FETCH);
	c_fault: cover property (@(posedge clk) done && fault);
endmodule

/* File: common/param_decode_map.svh */
// Offsets, field positions and codes of the two parameter blocks
`ifndef PARAM_DECODE_MAP_SVH
`define PARAM_DECODE_MAP_SVH

`define BLK_BYTES          512
`define BLK_ALIGN_BITS     9
`define WORD_BYTES         8
`define WORD_COUNT         64
`define WORD_IDX_W         6

// Report-target descriptor byte offsets
`define RT_MEAS_OFS        0
`define RT_ATTR_OFS        32
`define RT_CFA_OFS         48
`define RT_RSV49_OFS       49
`define RT_CFGVER_OFS      50
`define RT_MISC_OFS        52
`define RT_RSV56_OFS       56
`define RT_CFGID_OFS       64
`define RT_RSV128_OFS      128

// Key-derivation request byte offsets
`define KR_SEL_OFS         0
`define KR_POL_OFS         2
`define KR_VVER_OFS        4
`define KR_CFAM_OFS        6
`define KR_RSV7_OFS        7
`define KR_PVER_OFS        8
`define KR_AMASK_OFS       24
`define KR_NONCE_OFS       40
`define KR_MMASK_OFS       72
`define KR_CFGVER_OFS      76
`define KR_RSV78_OFS       78

// Policy bit positions
`define POL_ENCL_BIT       0
`define POL_SIGN_BIT       1
`define POL_OMIT_PROD_BIT  2
`define POL_CFGID_BIT      3
`define POL_FAMILY_BIT     4
`define POL_EXTPROD_BIT    5
`define POL_RSV_MASK       16'hFFC0

`define SEL_MAX            16'h0004

`endif

/* File: common/param_decode_pkg.sv */
// Types shared by the parameter decoder
package param_decode_pkg;

	typedef enum logic [2:0]
	{
		KEY_LAUNCH_TOKEN,
		KEY_PROVISIONING,
		KEY_PROVISIONING_SEAL,
		KEY_REPORT_AUTH,
		KEY_SEALING,
		KEY_RESERVED
	} key_kind_t;

	typedef enum logic [1:0]
	{
		OP_NONE,
		OP_REPORT_GENERATE,
		OP_KEY_FETCH
	} op_kind_t;

endpackage

/* File: hw/key_selector_decode.sv */
// Maps the raw key_selector field to a key kind
`timescale 1ns/10ps
`include "param_decode_map.svh"

module key_selector_decode
	import param_decode_pkg::*;
(
	// Raw field
	input  wire logic [15:0]           sel_raw,
	// Decoded
	output param_decode_pkg::key_kind_t kind,
	output logic                       reserved
);
	always_comb
	begin
		reserved = 1'b0;
		case (sel_raw)
			16'h0000: kind = KEY_LAUNCH_TOKEN;
			16'h0001: kind = KEY_PROVISIONING;
			16'h0002: kind = KEY_PROVISIONING_SEAL;
			16'h0003: kind = KEY_REPORT_AUTH;
			16'h0004: kind = KEY_SEALING;
			default:
			begin
				kind = KEY_RESERVED;
				reserved = 1'b1;
			end
		endcase
	end
endmodule

/* File: tb/block_mem_model.sv */
// Memory model of the parameter block that enclave software supplies
`timescale 1ns/10ps
module block_mem_model
(
	// Clock
	input  wire logic        clk,
	// Word read port
	input  wire logic        mem_rd,
	input  wire logic [63:0] mem_addr,
	output logic      [63:0] mem_data
);
	// One 512-byte block, filled directly by the bench between operations
	logic [4095:0] blk = '0;

	initial mem_data = 64'h0;

	always @(posedge clk)
	begin
		if (mem_rd === 1'b1)
			mem_data <= blk[64 * mem_addr[8:3] +: 64];
		else
			// Data is only valid one cycle; toggling keeps stale bits from matching
			mem_data <= ~mem_data;
	end
endmodule

/* File: tb/tb.sv */
// Self-checking bench of the parameter block decoder
`timescale 1ns/10ps
module tb;
	import param_decode_pkg::*;
	logic clk, srst, start, cap_ctl_flow, mem_rd, done, fault;
	op_kind_t op;
	key_kind_t key_kind;
	logic [63:0] pointer_register, mem_addr, mem_data;
	logic [255:0] own_enclave_measurement, own_signer_measurement, tgt_measurement;
	logic [255:0] wearout_nonce, drv_enclave_measurement, drv_signer_measurement;
	logic [127:0] own_attributes, own_family_identifier, own_extended_product_id;
	logic [127:0] tgt_attributes, processor_version, drv_attributes;
	logic [127:0] drv_family_identifier, drv_extended_product_id;
	logic [511:0] own_config_identifier, tgt_config_identifier, drv_config_identifier;
	logic [31:0] own_misc_select, tgt_misc_select, drv_misc_select;
	logic [15:0] own_product_identifier, tgt_config_version, vendor_version;
	logic [15:0] config_version, drv_product_identifier;
	logic [7:0] own_control_flow_attrs, tgt_control_flow_attrs, drv_control_flow_attrs;
	logic [511:0] pa, pb, pc, pd, pe, pg, ph;
	logic [5:0] p;
	int error_cnt = 0;
	int n_checks = 0;
	int rd_cnt = 0;
	int fo[10] = '{49, 56, 63, 128, 511, 7, 78, 511, 2, 6};
	logic [7:0] fv[10] = '{8'h01, 8'h01, 8'h80, 8'h01, 8'h01, 8'h01, 8'h01, 8'h80, 8'h40, 8'h01};
	localparam logic [63:0] BASE = 64'h0000_0000_0004_2200;

	key_request_target_decoder key_request_target_decoder_i
	(
		.clk, .srst, .start, .op, .pointer_register, .cap_ctl_flow, .mem_rd, .mem_addr,
		.mem_data, .own_enclave_measurement, .own_signer_measurement, .own_attributes,
		.own_misc_select, .own_control_flow_attrs, .own_product_identifier,
		.own_config_identifier, .own_family_identifier, .own_extended_product_id, .done,
		.fault, .key_kind, .tgt_measurement, .tgt_attributes, .tgt_control_flow_attrs,
		.tgt_config_version, .tgt_misc_select, .tgt_config_identifier, .vendor_version,
		.processor_version, .wearout_nonce, .config_version, .drv_attributes,
		.drv_misc_select, .drv_control_flow_attrs, .drv_enclave_measurement,
		.drv_signer_measurement, .drv_product_identifier, .drv_config_identifier,
		.drv_family_identifier, .drv_extended_product_id
	);

	block_mem_model mem_i (.clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_data(mem_data));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [511:0] pat(input logic [7:0] s);
		for (int i = 0; i < 64; i++)
			pat[8 * i +: 8] = s + 8'(i * 29);
	endfunction

	task automatic chk(input logic [511:0] g, input logic [511:0] e);
		n_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic put(input int ofs, input int n, input logic [511:0] v);
		for (int i = 0; i < n; i++)
			mem_i.blk[8 * (ofs + i) +: 8] = v[8 * i +: 8];
	endtask

	task automatic run(input op_kind_t o, input logic [63:0] ptr, input logic c);
		int n;
		@(posedge clk);
		start <= 1'b1;
		op <= o;
		pointer_register <= ptr;
		cap_ctl_flow <= c;
		@(posedge clk);
		start <= 1'b0;
		rd_cnt = 0;
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end
		while (done !== 1'b1 && n < 150);
		if (n >= 150)
			chk(0, 1);
	endtask

	task automatic test_done();
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk)
		if (mem_rd === 1'b1)
			rd_cnt++;

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		#200000;
		chk(0, 1);
		test_done();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		pa = pat(8'h11);
		pb = pat(8'h37);
		pc = pat(8'h5B);
		pd = pat(8'h74);
		pe = pat(8'h9C);
		pg = pat(8'hC3);
		ph = pat(8'hE8);
		srst = 1'b1;
		start = 1'b0;
		op = OP_NONE;
		pointer_register = 64'h0;
		cap_ctl_flow = 1'b0;
		own_enclave_measurement = pg[255:0];
		own_signer_measurement = pg[511:256];
		own_config_identifier = ~pg;
		own_attributes = ph[127:0];
		own_misc_select = ph[159:128];
		own_control_flow_attrs = ph[167:160];
		own_product_identifier = ph[183:168];
		own_family_identifier = ph[383:256];
		own_extended_product_id = ph[511:384];
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		#1;
		chk(fault, 0);
		chk(key_kind, KEY_RESERVED);
		// Descriptor fields, aligned block
		put(0, 32, pa);
		put(32, 16, pb);
		put(48, 1, pc);
		put(50, 2, pd);
		put(52, 4, pe);
		put(64, 64, pg);
		run(OP_REPORT_GENERATE, BASE, 1'b1);
		chk(fault, 0);
		chk(rd_cnt, 64);
		chk(tgt_measurement, pa[255:0]);
		chk(tgt_attributes, pb[127:0]);
		chk(tgt_control_flow_attrs, pc[7:0]);
		chk(tgt_config_version, pd[15:0]);
		chk(tgt_misc_select, pe[31:0]);
		chk(tgt_config_identifier, pg);
		run(OP_REPORT_GENERATE, BASE, 1'b0);
		chk(fault, 1);
		chk(tgt_control_flow_attrs, 0);
		// Request fields and every policy combination
		mem_i.blk = '0;
		put(0, 2, 16'h0004);
		put(4, 2, pd);
		put(6, 1, pc);
		put(8, 16, pa);
		put(24, 16, pb);
		put(40, 32, pg);
		put(72, 4, pe);
		put(76, 2, ph);
		for (int k = 0; k < 64; k++)
		begin
			p = 6'(k);
			put(2, 2, 16'(k));
			run(OP_KEY_FETCH, BASE + 64'h200, 1'b1);
			chk(fault, 0);
			chk(drv_enclave_measurement, p[0] ? own_enclave_measurement : 256'h0);
			chk(drv_signer_measurement, p[1] ? own_signer_measurement : 256'h0);
			chk(drv_product_identifier, p[2] ? 16'h0 : own_product_identifier);
			chk(drv_config_identifier, p[3] ? own_config_identifier : 512'h0);
			chk(drv_family_identifier, p[4] ? own_family_identifier : 128'h0);
			chk(drv_extended_product_id, p[5] ? own_extended_product_id : 128'h0);
		end
		chk(key_kind, KEY_SEALING);
		chk(vendor_version, pd[15:0]);
		chk(processor_version, pa[127:0]);
		chk(drv_attributes, own_attributes & pb[127:0]);
		chk(wearout_nonce, pg[255:0]);
		chk(drv_misc_select, own_misc_select & pe[31:0]);
		chk(config_version, ph[15:0]);
		chk(drv_control_flow_attrs, own_control_flow_attrs & pc[7:0]);
		run(OP_KEY_FETCH, BASE, 1'b0);
		chk(fault, 1);
		chk(drv_control_flow_attrs, 0);
		// Every defined selector value, and one reserved value
		for (int s = 0; s < 6; s++)
		begin
			put(0, 2, 16'(s));
			run(OP_KEY_FETCH, BASE, 1'b1);
			chk(key_kind, key_kind_t'(s));
			chk(fault, s == 5);
		end
		// Misaligned pointer faults without reading
		run(OP_KEY_FETCH, BASE + 64'h40, 1'b1);
		chk(fault, 1);
		chk(rd_cnt, 0);
		// Nonzero reserved bytes and bits
		for (int k = 0; k < 10; k++)
		begin
			mem_i.blk = '0;
			if (k >= 5)
				put(0, 2, 16'h0004);
			put(fo[k], 1, fv[k]);
			run(k < 5 ? OP_REPORT_GENERATE : OP_KEY_FETCH, BASE, k != 9);
			chk(fault, 1);
		end
		test_done();
	end
endmodule
